// ### src/fsp_pkg.sv
// Constants shared by the flash sector protection host controller
package fsp_pkg;
  // Clock period of clk_sys_i in ns (200 MHz)
  localparam int CLK_NS = 5;
  // Flash timing figures in ns
  localparam int UNLOCK_SPACING_NS = 1000;
  localparam int UNLOCK_SETTLE_NS = 1000;
  localparam int MIN_RESET_PULSE_NS = 500;
  localparam int ADDRESS_ACCESS_TIME_NS = 70;
  localparam int WE_PULSE_NS = 35;
  localparam int SLEEP_EXTRA_NS = 30;
  // Least times round up to whole cycles
  localparam logic [15:0] UNLOCK_SPACING_CYC =
    16'((UNLOCK_SPACING_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] UNLOCK_SETTLE_CYC =
    16'((UNLOCK_SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] RESET_PULSE_CYC =
    16'((MIN_RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] ACCESS_CYC =
    16'((ADDRESS_ACCESS_TIME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] WE_PULSE_CYC =
    16'((WE_PULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] SLEEP_CYC =
    16'((ADDRESS_ACCESS_TIME_NS + SLEEP_EXTRA_NS + CLK_NS - 1) / CLK_NS);
  // Widths
  localparam int ADDR_W = 26;
  localparam int DATA_W = 16;
  localparam int PWD_WORDS = 4;
  // Software register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_CMD = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_PWD0 = 8'h18;
  localparam logic [7:0] REG_SECT = 8'h28;
  // Field positions
  localparam int CTRL_WP_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_SUPPLY_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;
  localparam int SECT_PERS_BIT = 0;
  localparam int SECT_VOL_BIT = 1;
  localparam int SECT_OUTER_BIT = 2;
  localparam int SECT_PROT_BIT = 3;
  // Reset values
  localparam logic [DATA_W-1:0] PWD_RESET = 16'hffff;
  localparam logic CTRL_WP_RESET = 1'b1;
  // Command codes written to REG_CMD
  localparam logic [2:0] CMD_WRITE = 3'h1;
  localparam logic [2:0] CMD_READ = 3'h2;
  localparam logic [2:0] CMD_UNLOCK = 3'h3;
  localparam logic [2:0] CMD_RESET = 3'h4;
  // Controller states
  typedef enum logic [2:0] {
    FSP_IDLE, FSP_GAP, FSP_SETUP, FSP_STROBE, FSP_HOLD, FSP_SETTLE, FSP_RST
  } fsp_state_t;
endpackage

// ### src/fsp_host.sv
// Host-side controller driving a parallel NOR flash with sector password protection
//
// Overview of operation
// - Lowest two address bits select password part
// - Unlock commands spaced at least one microsecond
// - Entry sequence first; sector zero blocked; the controller sends no entry sequence and blocks no sector
// - Write protect stable during command sequences
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module fsp_host
  import fsp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Software register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Flash pins
  output logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] flash_dq_i,
  output logic [DATA_W-1:0] flash_dq_o,
  output logic flash_dq_oe_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic flash_reset_n_o,
  output logic write_protect_n_o,
  input wire logic supply_lockout_i
);
  // Software-visible state
  logic wp_req_r, wp_req_nxt;
  logic [ADDR_W-1:0] base_addr_r, base_addr_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [DATA_W-1:0] pwd_r [PWD_WORDS], pwd_nxt [PWD_WORDS];
  logic sect_pers_r, sect_pers_nxt;
  logic sect_vol_r, sect_vol_nxt;
  logic sect_outer_r, sect_outer_nxt;
  logic refused_r, refused_nxt;
  logic [31:0] bus_rdata_r, bus_rdata_nxt;
  // Sequencer state
  fsp_state_t state_r, state_nxt;
  logic [2:0] op_r, op_nxt;
  logic [1:0] word_r, word_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] spacing_r, spacing_nxt;
  logic [15:0] sleep_cnt_r, sleep_cnt_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt;
  logic dq_oe_r, dq_oe_nxt;
  logic ce_n_r, ce_n_nxt;
  logic oe_n_r, oe_n_nxt;
  logic we_n_r, we_n_nxt;
  logic rst_n_r, rst_n_nxt;
  logic wp_pin_r, wp_pin_nxt;
  logic busy, cmd_wr, sect_protected;
  logic [2:0] cmd_code;
  assign busy = (state_r != FSP_IDLE);
  assign cmd_wr = reg_wr_i && (reg_addr_i == REG_CMD);
  assign cmd_code = reg_wdata_i[2:0];
  // Protection verdict from the status bits software read back
  // persistent then volatile
  assign sect_protected = !sect_pers_r || !sect_vol_r || (sect_outer_r && !wp_pin_r);
  // Register writes and read data, answered one cycle after the strobe
  always_comb begin
    wp_req_nxt = wp_req_r;
    base_addr_nxt = base_addr_r;
    wdata_nxt = wdata_r;
    sect_pers_nxt = sect_pers_r;
    sect_vol_nxt = sect_vol_r;
    sect_outer_nxt = sect_outer_r;
    bus_rdata_nxt = 32'h0000_0000;
    pwd_nxt = pwd_r;
    if (reg_wr_i) begin
      case (reg_addr_i)
        REG_CTRL: wp_req_nxt = reg_wdata_i[CTRL_WP_BIT];
        REG_ADDR: base_addr_nxt = reg_wdata_i[ADDR_W-1:0];
        REG_WDATA: wdata_nxt = reg_wdata_i[DATA_W-1:0];
        REG_SECT: begin
          sect_pers_nxt = reg_wdata_i[SECT_PERS_BIT];
          sect_vol_nxt = reg_wdata_i[SECT_VOL_BIT];
          sect_outer_nxt = reg_wdata_i[SECT_OUTER_BIT];
        end
        default: begin
          for (int i = 0; i < PWD_WORDS; i++) begin
            if (reg_addr_i == REG_PWD0 + 8'(4 * i)) begin
              pwd_nxt[i] = reg_wdata_i[DATA_W-1:0];
            end
          end
        end
      endcase
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL: bus_rdata_nxt[CTRL_WP_BIT] = wp_req_r;
        REG_ADDR: bus_rdata_nxt[ADDR_W-1:0] = base_addr_r;
        REG_WDATA: bus_rdata_nxt[DATA_W-1:0] = wdata_r;
        REG_STATUS: begin
          bus_rdata_nxt[ST_BUSY_BIT] = busy;
          bus_rdata_nxt[ST_SUPPLY_BIT] = supply_lockout_i;
          bus_rdata_nxt[ST_SLEEP_BIT] = (sleep_cnt_r >= SLEEP_CYC);
          bus_rdata_nxt[ST_REFUSED_BIT] = refused_r;
        end
        REG_RDATA: bus_rdata_nxt[DATA_W-1:0] = rdata_r;
        REG_SECT: begin
          bus_rdata_nxt[SECT_PERS_BIT] = sect_pers_r;
          bus_rdata_nxt[SECT_VOL_BIT] = sect_vol_r;
          bus_rdata_nxt[SECT_OUTER_BIT] = sect_outer_r;
          bus_rdata_nxt[SECT_PROT_BIT] = sect_protected;
        end
        // Password words are write-only so they never leak back out
        default: bus_rdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  // Flash cycle sequencer
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    word_nxt = word_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    dq_nxt = dq_r;
    dq_oe_nxt = dq_oe_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    rst_n_nxt = rst_n_r;
    wp_pin_nxt = wp_pin_r;
    rdata_nxt = rdata_r;
    refused_nxt = refused_r;
    spacing_nxt = (spacing_r == 16'hffff) ? spacing_r : spacing_r + 16'h0001;
    case (state_r)
      FSP_IDLE: begin
        wp_pin_nxt = wp_req_r;
        if (cmd_wr) begin
          op_nxt = cmd_code;
          word_nxt = 2'h0;
          cnt_nxt = 16'h0000;
          refused_nxt = 1'b0;
          addr_nxt = base_addr_r;
          dq_nxt = wdata_r;
          case (cmd_code)
            // entry sequence issued as plain writes
            CMD_WRITE: begin
              if (supply_lockout_i) begin
                refused_nxt = 1'b1;
              end else begin
                state_nxt = FSP_SETUP;
              end
            end
            CMD_READ: state_nxt = FSP_SETUP;
            CMD_UNLOCK: begin
              if (supply_lockout_i) begin
                refused_nxt = 1'b1;
              end else begin
                addr_nxt = {base_addr_r[ADDR_W-1:2], 2'h0};
                dq_nxt = pwd_r[0];
                state_nxt = FSP_GAP;
              end
            end
            CMD_RESET: begin
              rst_n_nxt = 1'b0;
              state_nxt = FSP_RST;
            end
            default: refused_nxt = 1'b1;
          endcase
        end
      end
      FSP_GAP: begin
        if (spacing_r >= UNLOCK_SPACING_CYC) begin
          state_nxt = FSP_SETUP;
        end
      end
      FSP_SETUP: begin
        // Address settles one cycle before the strobe; chip enable falls with the strobe
        ce_n_nxt = 1'b0;
        dq_oe_nxt = (op_r != CMD_READ);
        cnt_nxt = 16'h0000;
        if (op_r == CMD_READ) begin
          oe_n_nxt = 1'b0;
        end else begin
          we_n_nxt = 1'b0;
        end
        state_nxt = FSP_STROBE;
      end
      FSP_STROBE: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (op_r == CMD_READ) begin
          if (cnt_r + 16'h0001 >= ACCESS_CYC) begin
            rdata_nxt = flash_dq_i;
            oe_n_nxt = 1'b1;
            state_nxt = FSP_HOLD;
          end
        end else if (cnt_r + 16'h0001 >= WE_PULSE_CYC) begin
          we_n_nxt = 1'b1;
          state_nxt = FSP_HOLD;
        end
      end
      FSP_HOLD: begin
        // Data held past the rising strobe, then the bus is released
        ce_n_nxt = 1'b1;
        dq_oe_nxt = 1'b0;
        cnt_nxt = 16'h0000;
        if (op_r == CMD_UNLOCK && word_r != 2'h3) begin
          word_nxt = word_r + 2'h1;
          addr_nxt = {addr_r[ADDR_W-1:2], word_r + 2'h1};
          dq_nxt = pwd_r[word_r + 2'h1];
          state_nxt = FSP_SETUP;
        end else if (op_r == CMD_UNLOCK) begin
          spacing_nxt = 16'h0000;
          state_nxt = FSP_SETTLE;
        end else begin
          state_nxt = FSP_IDLE;
        end
      end
      FSP_SETTLE: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 >= UNLOCK_SETTLE_CYC) begin
          state_nxt = FSP_IDLE;
        end
      end
      FSP_RST: begin
        cnt_nxt = cnt_r + 16'h0001;
        if (cnt_r + 16'h0001 >= RESET_PULSE_CYC) begin
          rst_n_nxt = 1'b1;
          state_nxt = FSP_IDLE;
        end
      end
      default: state_nxt = FSP_IDLE;
    endcase
  end
  always_comb begin
    sleep_cnt_nxt = (sleep_cnt_r >= SLEEP_CYC) ? sleep_cnt_r : sleep_cnt_r + 16'h0001;
    if (addr_nxt != addr_r) begin
      sleep_cnt_nxt = 16'h0000;
    end
  end
  // Register stage; reset starts with a flash reset pulse and strobes high
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wp_req_r <= CTRL_WP_RESET;
      base_addr_r <= '0;
      wdata_r <= '0;
      rdata_r <= '0;
      pwd_r <= '{default: PWD_RESET};
      sect_pers_r <= 1'b1;
      sect_vol_r <= 1'b1;
      sect_outer_r <= 1'b0;
      refused_r <= 1'b0;
      bus_rdata_r <= 32'h0000_0000;
      state_r <= FSP_RST;
      op_r <= CMD_RESET;
      word_r <= 2'h0;
      cnt_r <= 16'h0000;
      spacing_r <= 16'hffff;
      sleep_cnt_r <= 16'h0000;
      addr_r <= '0;
      dq_r <= '0;
      dq_oe_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      rst_n_r <= 1'b0;
      wp_pin_r <= CTRL_WP_RESET;
    end else begin
      wp_req_r <= wp_req_nxt;
      base_addr_r <= base_addr_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      pwd_r <= pwd_nxt;
      sect_pers_r <= sect_pers_nxt;
      sect_vol_r <= sect_vol_nxt;
      sect_outer_r <= sect_outer_nxt;
      refused_r <= refused_nxt;
      bus_rdata_r <= bus_rdata_nxt;
      state_r <= state_nxt;
      op_r <= op_nxt;
      word_r <= word_nxt;
      cnt_r <= cnt_nxt;
      spacing_r <= spacing_nxt;
      sleep_cnt_r <= sleep_cnt_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      dq_oe_r <= dq_oe_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      rst_n_r <= rst_n_nxt;
      wp_pin_r <= wp_pin_nxt;
    end
  end
  assign reg_rdata_o = bus_rdata_r;
  assign flash_addr_o = addr_r;
  assign flash_dq_o = dq_r;
  assign flash_dq_oe_o = dq_oe_r;
  assign flash_ce_n_o = ce_n_r;
  assign flash_oe_n_o = oe_n_r;
  assign flash_we_n_o = we_n_r;
  assign flash_reset_n_o = rst_n_r;
  assign write_protect_n_o = wp_pin_r;
endmodule
`default_nettype wire

// ### test/fsp_host_sva.sv
// Port checker for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fsp_host_sva
  import fsp_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [ADDR_W-1:0] flash_addr_o,
  input wire logic [DATA_W-1:0] flash_dq_o,
  input wire logic flash_dq_oe_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic flash_reset_n_o,
  input wire logic write_protect_n_o
);
  logic [7:0] low_r;
  logic [7:0] gap_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Saturating counters, so a long idle never wraps into a false short gap
  always_ff @(posedge clk_sys_i) begin
    if (flash_reset_n_o) low_r <= 8'h00;
    else if (reset_i) low_r <= 8'h01;
    else if (low_r != 8'hff) low_r <= low_r + 8'h01;
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) gap_r <= 8'hff;
    else if ($fell(flash_we_n_o) && flash_addr_o[1:0] == 2'h0) gap_r <= 8'h00;
    else if (gap_r != 8'hff) gap_r <= gap_r + 8'h01;
  end
  sequence we_pulse_s;
    !flash_we_n_o [*7] ##1 flash_we_n_o;
  endsequence
  sequence access_s;
    ##13 !flash_oe_n_o ##1 flash_oe_n_o;
  endsequence
  rst_width_a: assert property (
    $rose(flash_reset_n_o) |-> low_r >= 8'h64) else $error("flash reset pulse short");
  we_width_a: assert property (
    $fell(flash_we_n_o) |-> we_pulse_s) else $error("write pulse width wrong");
  rd_access_a: assert property (
    $fell(flash_oe_n_o) |-> access_s) else $error("read access width wrong");
  unlock_gap_a: assert property (
    $fell(flash_we_n_o) && flash_addr_o[1:0] == 2'h0 |-> gap_r >= 8'hc7)
    else $error("unlock attempts too close");
  wp_stable_a: assert property (
    !flash_ce_n_o |-> $stable(write_protect_n_o)) else $error("protect pin moved in cycle");
  addr_hold_a: assert property (
    !flash_we_n_o && !$fell(flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o))
    else $error("address or data moved in write");
  bus_turn_a: assert property (
    flash_dq_oe_o |-> !flash_ce_n_o && flash_oe_n_o) else $error("data driven outside write");
  rdata_idle_a: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data outside slot");
endmodule
bind fsp_host fsp_host_sva i_sva (.clk_sys_i, .reset_i, .reg_rd_i, .reg_rdata_o, .flash_addr_o,
  .flash_dq_o, .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o,
  .write_protect_n_o);
`default_nettype wire

// ### test/fsp_flash_model.sv
// Behavioural flash device with a password-guarded global freeze
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model
  import fsp_pkg::*;
(
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic supply_lockout_i,
  output logic [DATA_W-1:0] dq_o
);
  // Top address bit picks the password region; an arbitrary map for this model
  localparam logic PWD_LOCKED = 1'b0;
  logic [DATA_W-1:0] pwd [PWD_WORDS] = '{default: 16'hffff};
  logic [DATA_W-1:0] last = 16'h0;
  logic hit = 1'b0;
  logic ok = 1'b0;
  realtime t_ok = 0.0;
  realtime t_try = -2000.0;
  always @(negedge reset_n_i) ok = 1'b0;
  // writes need supply, select, reset released
  always @(posedge we_n_i) begin
    if (!ce_n_i && reset_n_i && !supply_lockout_i) begin
      if (addr_i[ADDR_W-1]) begin
        if (!PWD_LOCKED) pwd[addr_i[1:0]] = pwd[addr_i[1:0]] & dq_i;
      end else if (addr_i[1:0] == 2'h0) begin
        hit = ($realtime - t_try >= 1000.0) && dq_i == pwd[0];
        t_try = $realtime;
      end else begin
        hit = hit && dq_i == pwd[addr_i[1:0]];
        if (hit && addr_i[1:0] == 2'h3) begin
          ok = 1'b1;
          t_ok = $realtime;
        end
      end
    end
  end
  always @* begin
    if (!ce_n_i && !oe_n_i && reset_n_i) begin
      if (addr_i[ADDR_W-1] && !PWD_LOCKED) last = pwd[addr_i[1:0]];
      else last = {15'h0, ok && $realtime - t_ok >= 1000.0};
      dq_o = last;
    end else begin
      // Released bus shows inverted data so a stale value cannot pass
      dq_o = ~last;
    end
  end
endmodule
`default_nettype wire

// ### test/test_fsp_host.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module test_fsp_host
  import fsp_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic supply_lockout_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic [ADDR_W-1:0] flash_addr_o;
  logic [DATA_W-1:0] flash_dq_o, mdl_dq;
  logic flash_dq_oe_o, flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_reset_n_o;
  logic write_protect_n_o;
  int failures = 0;
  int n_checks = 0;
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  // Data wire level follows whoever drives it
  fsp_host i_dut (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .flash_addr_o, .flash_dq_i(flash_dq_oe_o ? flash_dq_o : mdl_dq), .flash_dq_o,
    .flash_dq_oe_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_reset_n_o,
    .write_protect_n_o, .supply_lockout_i);
  fsp_flash_model i_flash (.addr_i(flash_addr_o), .dq_i(flash_dq_o), .ce_n_i(flash_ce_n_o),
    .oe_n_i(flash_oe_n_o), .we_n_i(flash_we_n_o), .reset_n_i(flash_reset_n_o),
    .supply_lockout_i, .dq_o(mdl_dq));
  task automatic summarize();
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Register port cycles, driven just after the clock edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Bounded poll; a hung controller shows as a busy mismatch
  task automatic idle();
    logic [31:0] s;
    s = 32'h1;
    for (int i = 0; i < 400 && s[ST_BUSY_BIT] !== 1'b0; i++) rd(REG_STATUS, s);
    chk("busy", 32'h0, {31'h0, s[ST_BUSY_BIT]});
  endtask
  task automatic fop(input logic [2:0] c, input logic [ADDR_W-1:0] a, input logic [15:0] d);
    wr(REG_ADDR, {6'h0, a});
    wr(REG_WDATA, {16'h0, d});
    wr(REG_CMD, {29'h0, c});
    idle();
  endtask
  task automatic rdf(input logic [ADDR_W-1:0] a, input logic [31:0] e, input string what);
    logic [31:0] v;
    fop(CMD_READ, a, 16'h0);
    rd(REG_RDATA, v);
    chk(what, e, v);
  endtask
  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    idle();
    rd(REG_CTRL, v);
    chk("ctrl", 32'h1, v);
    rd(8'h30, v);
    chk("unmapped", 32'h0, v);
    rd(REG_PWD0, v);
    chk("pwd_reg", 32'h0, v);
    repeat (30) @(posedge clk_sys_i);
    rd(REG_STATUS, v);
    chk("sleep", 32'h4, v & 32'hf);
    rdf('0, 32'h0, "freeze_init");
    rdf({1'b1, 25'h2}, 32'hffff, "pwd_ones");
    fop(CMD_WRITE, {1'b1, 25'h2}, 16'h0f0f);
    fop(CMD_WRITE, {1'b1, 25'h2}, 16'hf0ff);
    rdf({1'b1, 25'h2}, 32'h000f, "pwd_and");
    wr(REG_ADDR, 32'h0);
    // Two wrong attempts back to back, then the right one
    repeat (2) fop(CMD_UNLOCK, '0, 16'h0);
    rdf('0, 32'h0, "freeze_wrong");
    wr(REG_PWD0 + 8'h08, 32'h000f);
    fop(CMD_UNLOCK, '0, 16'h0);
    rdf('0, 32'h1, "freeze_open");
    fop(CMD_RESET, '0, 16'h0);
    rdf('0, 32'h0, "freeze_reset");
    supply_lockout_i <= 1'b1;
    fop(CMD_WRITE, {1'b1, 25'h1}, 16'h0);
    rd(REG_STATUS, v);
    chk("refused", 32'ha, v & 32'hb);
    supply_lockout_i <= 1'b0;
    rdf({1'b1, 25'h1}, 32'hffff, "lockout_kept");
    for (int i = 0; i < 16; i++) begin
      wr(REG_CTRL, {31'h0, i[3]});
      wr(REG_SECT, {29'h0, i[2:0]});
      rd(REG_SECT, v);
      chk("sect", {28'h0, !i[0] || !i[1] || (i[2] && !i[3]), i[2:0]}, v);
      chk("wp_pin", {31'h0, i[3]}, {31'h0, write_protect_n_o});
    end
    summarize();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    failures++;
    summarize();
  end
endmodule
`default_nettype wire
